// ### bench/uam_host_model.sv
// Purpose: apb host that reads and clears the alarm registers
// Assumes: answer is pready high at a rising edge
// Notes: a wait that runs out bumps timeouts instead of hanging
module uam_host_model (
  // clock
  input wire logic clk_i,
  // apb master
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int timeouts = 0;
  logic err = 1'b0;
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end
  // clearing is only ever a write of one to the flag
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 32);
    if (pready_i !== 1'b1) timeouts++;
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// ### bench/upset_alarm_monitor_test.sv
// Purpose: self-checking bench for the upset alarm monitor
// Assumes: status is visible one edge after its source
// Notes: sources are pulsed for one cycle through the hit vector
module upset_alarm_monitor_test
  import uam_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] hit = 7'h00;
  logic [31:0] acc = 32'h0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic lrst, spd, gate, alarm, pin;
  logic lmfc, ilas;
  int g;
  int bad_count = 0;
  int comparisons = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  // running accumulators so a one-cycle mismatch is a real difference
  always_ff @(posedge clk) acc <= acc + 32'h1001;
  uam_alarm_monitor #(.LANES(16), .LMFC_LEN(8)) uam_alarm_monitor_inst (
    .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LANE_FIFO_ERR_I(hit[6] ? 16'h0020 : 16'h0000), .PLL_LOCKED_I(~hit[0]),
    .SYSREF_REALIGN_I(hit[1]), .SYSREF_I(hit[2]), .SYNC_START_I(hit[3]),
    .PHASE_ACC_A_I(acc), .PHASE_ACC_B_I(acc ^ {31'h0, hit[5]}),
    .CLOCKS_A_I(acc[3:0]), .CLOCKS_B_I(acc[3:0] ^ {3'h0, hit[4]}),
    .LINK_RESET_O(lrst), .SER_POWER_DOWN_O(spd), .LINK_CLK_GATE_O(gate),
    .LMFC_EDGE_O(lmfc), .ILAS_START_O(ilas), .ALARM_O(alarm), .CAL_RESULT_PIN_O(pin));
  uam_host_model uam_host_model_inst (
    .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    uam_host_model_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    uam_host_model_inst.xfer(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    hit[i] <= 1'b1;
    @(posedge clk);
    hit[i] <= 1'b0;
    @(posedge clk);
  endtask
  // receiver side: cycles between two release points on the lmfc edge
  task automatic edge_gap(output int gap);
    int n;
    n = 0;
    gap = 0;
    do begin
      @(posedge clk);
      n++;
    end while (lmfc !== 1'b1 && n < 64);
    do begin
      @(posedge clk);
      gap++;
    end while (lmfc !== 1'b1 && gap < 64);
  endtask
  task automatic print_verdict();
    bad_count += uam_host_model_inst.timeouts;
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS, 32'h0, "status reset");
    rd(ADDR_MASK, 32'(MASK_RESET), "mask reset");
    chk(32'(uam_host_model_inst.err), 32'h0, "mapped err");
    rd(8'h14, 32'h0, "unmapped read");
    chk(32'(uam_host_model_inst.err), 32'h1, "unmapped err");
    chk({29'h0, lrst, spd, gate}, 32'h7, "link held");
    pulse(0);
    rd(ADDR_STATUS, 1 << BIT_PLL, "pll alarm");
    chk(32'(alarm), 32'h0, "masked");
    wr(ADDR_MASK, 32'h3f ^ (1 << BIT_PLL));
    rd(ADDR_STATUS, 1 << BIT_PLL, "sticky");
    chk(32'(alarm | pin), 32'h1, "unmasked");
    wr(ADDR_CTRL, 1 << CTRL_PIN_SEL);
    // the pin takes the new select one edge late, then settles
    repeat (2) @(posedge clk);
    chk(32'(pin), 32'h1, "pin");
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS, 1 << BIT_PLL, "zero kept");
    wr(ADDR_STATUS, 1 << BIT_PLL);
    rd(ADDR_STATUS, 32'h0, "one clears");
    chk(32'(alarm | pin), 32'h0, "dropped");
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_STATUS, 1 << BIT_LINK, "link idle");
    chk(32'(alarm & pin), 32'h1, "link out");
    chk({29'h0, lrst, spd, gate}, 32'h0, "link runs");
    pulse(3);
    chk(32'(ilas), 32'h1, "ilas start");
    rd(ADDR_SUMMARY, 32'(LS_DATA), "data");
    wr(ADDR_STATUS, 1 << BIT_LINK);
    rd(ADDR_STATUS, 32'h0, "link ok");
    pulse(5);
    rd(ADDR_STATUS, 32'h0, "osc unarmed");
    pulse(2);
    // second sysref three cycles on, away from any free-running wrap
    pulse(2);
    chk(32'(lmfc), 32'h1, "sysref edge");
    pulse(5);
    pulse(4);
    pulse(6);
    pulse(1);
    rd(ADDR_STATUS, 32'h39, "sources");
    edge_gap(g);
    chk(32'(g), 32'h8, "lmfc period");
    rd(ADDR_LANES, 32'h20, "lane");
    wr(ADDR_LANES, 32'h20);
    rd(ADDR_LANES, 32'h0, "lane clr");
    wr(ADDR_STATUS, 32'h3f);
    wr(ADDR_CTRL, 32'h7);
    pulse(6);
    rd(ADDR_STATUS, 32'h5, "reinit");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STATUS, 32'h3f);
    wr(ADDR_CTRL, 32'h9);
    pulse(5);
    pulse(3);
    pulse(5);
    rd(ADDR_STATUS, 32'h14, "osc after ilas");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h11);
    // 64b/66b reaches data two edges after enable, with no sync request
    @(posedge clk);
    rd(ADDR_SUMMARY, 32'(LS_DATA), "64b data");
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_SUMMARY, 32'(LS_OFF), "off");
    chk({29'h0, lrst, spd, gate}, 32'h7, "held");
    print_verdict();
  end
endmodule

// ### hw/uam_alarm_monitor.sv
// Purpose: sticky alarm monitor with APB access, LMFC/LEMC and link control
// Assumes: all inputs synchronous to CLOCK_I (device clock / 2)
// Notes: zero wait-state APB slave
// Summary of operation
// - each alarm source sets its own sticky status bit
// - a status bit clears only when host writes one to it
// - unmasked alarms show on the summary alarm indication
// - with pin select set, calibration pin goes high on alarm
// - alarm whenever serializer PLL not locked
// - alarm when link enabled but not in data transmission state
// - alarm when SYSREF realigns internal clocks
// - any one-cycle phase accumulator mismatch sets oscillator upset flag
// - oscillator detection valid only after NCO sync by selected source
// - one-cycle channel clock mismatch sets clock upset flag
// - clock flag may set on power-down exit; host clears it
// - any lane FIFO overflow or underflow while link enabled sets lane buffer flag
// - per-lane bit marks each upset lane
// - auto reinit resets the link (LINK_RESET_O, link state) on FIFO upset; serializers stay powered
// - SYSREF resets LMFC or LEMC depending on encoding
// - without SYSREF, LMFC self-runs and SYNC still starts CGS/ILAS
// - link enable low holds link in reset, serializers off, clocks gated
module uam_alarm_monitor
  import uam_pkg::*;
#(
  parameter int LANES = DEFAULT_LANES,
  parameter int LMFC_LEN = DEFAULT_LMFC_LEN
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // alarm sources
  input wire logic [LANES-1:0] LANE_FIFO_ERR_I,
  input wire logic PLL_LOCKED_I,
  input wire logic SYSREF_REALIGN_I,
  input wire logic SYSREF_I,
  input wire logic SYNC_START_I,
  input wire logic [31:0] PHASE_ACC_A_I,
  input wire logic [31:0] PHASE_ACC_B_I,
  input wire logic [3:0] CLOCKS_A_I,
  input wire logic [3:0] CLOCKS_B_I,
  // link controls and indications
  output logic LINK_RESET_O,
  output logic SER_POWER_DOWN_O,
  output logic LINK_CLK_GATE_O,
  output logic LMFC_EDGE_O,
  output logic ILAS_START_O,
  output logic ALARM_O,
  output logic CAL_RESULT_PIN_O
);

  // per-lane bits must fit one 32-bit register word; the lmfc counter is 8 bits
  if (LANES < 1 || LANES > 32) begin
    $error("LANES must be 1..32");
  end
  if (LMFC_LEN < 2 || LMFC_LEN > 256) begin
    $error("LMFC_LEN must be 2..256");
  end

  logic [NUM_ALARMS-1:0] alarm_status_bits;
  logic [NUM_ALARMS-1:0] alarm_mask;
  logic [4:0] ctrl;
  logic [LANES-1:0] per_lane_upset_bits;
  uam_link_e link_state;
  logic osc_armed;
  logic [7:0] lmfc_cnt;
  logic reinit;
  logic [NUM_ALARMS-1:0] events;
  logic [NUM_ALARMS-1:0] clr;
  logic [LANES-1:0] lane_clr;
  logic wr_access;
  logic mapped;
  logic link_enable;
  logic nco_sync;

  assign link_enable = ctrl[CTRL_LINK_EN];
  assign wr_access = PSEL_I && PENABLE_I && PWRITE_I;
  assign mapped = PADDR_I inside {ADDR_STATUS, ADDR_MASK, ADDR_CTRL, ADDR_LANES, ADDR_SUMMARY};
  assign clr = (wr_access && PADDR_I == ADDR_STATUS) ? PWDATA_I[NUM_ALARMS-1:0] : '0;
  assign lane_clr = (wr_access && PADDR_I == ADDR_LANES) ? PWDATA_I[LANES-1:0] : '0;
  // sync source: 0 = SYSREF, 1 = start of ILAS
  assign nco_sync = ctrl[CTRL_SYNC_SRC] ? ILAS_START_O : SYSREF_I;

  always_comb begin
    events = '0;
    events[BIT_FIFO] = link_enable && |LANE_FIFO_ERR_I;
    events[BIT_PLL] = !PLL_LOCKED_I;
    events[BIT_LINK] = link_enable && link_state != LS_DATA;
    events[BIT_SYSREF] = SYSREF_REALIGN_I;
    // comparison ignored until accumulators were synchronised
    events[BIT_OSC] = osc_armed && (PHASE_ACC_A_I != PHASE_ACC_B_I);
    events[BIT_CLK] = CLOCKS_A_I != CLOCKS_B_I;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      alarm_status_bits <= '0;
    end else begin
      alarm_status_bits <= (alarm_status_bits & ~clr) | events;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      per_lane_upset_bits <= '0;
    end else begin
      per_lane_upset_bits <= (per_lane_upset_bits & ~lane_clr)
        | (link_enable ? LANE_FIFO_ERR_I : '0);
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      alarm_mask <= MASK_RESET;
      ctrl <= CTRL_RESET;
    end else if (wr_access) begin
      if (PADDR_I == ADDR_MASK) alarm_mask <= PWDATA_I[NUM_ALARMS-1:0];
      if (PADDR_I == ADDR_CTRL) ctrl <= PWDATA_I[4:0];
    end
  end

  // disabling the link drops the arming, so the host must resync
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_armed <= 1'b0;
    end else if (!link_enable) begin
      osc_armed <= 1'b0;
    end else if (nco_sync) begin
      osc_armed <= 1'b1;
    end
  end

  // reinit follows the FIFO event one cycle late and lasts as long as it, taking link back through sync
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      reinit <= 1'b0;
    end else begin
      reinit <= ctrl[CTRL_AUTO_REINIT] && events[BIT_FIFO];
    end
  end

  // lmfc/lemc free-runs when no SYSREF arrives (subclass 0)
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      lmfc_cnt <= '0;
    end else if (SYSREF_I) begin
      lmfc_cnt <= '0;
    end else if (lmfc_cnt == 8'(LMFC_LEN - 1)) begin
      lmfc_cnt <= '0;
    end else begin
      lmfc_cnt <= lmfc_cnt + 8'h01;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      LMFC_EDGE_O <= 1'b0;
    end else begin
      LMFC_EDGE_O <= SYSREF_I || lmfc_cnt == 8'(LMFC_LEN - 1);
    end
  end

  // 64b/66b has no ILAS: data follows sync directly
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      link_state <= LS_OFF;
      ILAS_START_O <= 1'b0;
    end else begin
      ILAS_START_O <= 1'b0;
      if (!link_enable || reinit) begin
        link_state <= LS_OFF;
      end else begin
        unique case (link_state)
          LS_OFF: link_state <= LS_SYNC;
          LS_SYNC: begin
            if (SYNC_START_I || ctrl[CTRL_ENC_64B]) begin
              link_state <= LS_DATA;
              ILAS_START_O <= !ctrl[CTRL_ENC_64B];
            end
          end
          LS_DATA: link_state <= LS_DATA;
          default: link_state <= LS_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      LINK_RESET_O <= 1'b1;
      SER_POWER_DOWN_O <= 1'b1;
      LINK_CLK_GATE_O <= 1'b1;
    end else begin
      LINK_RESET_O <= !link_enable || reinit;
      SER_POWER_DOWN_O <= !link_enable;
      LINK_CLK_GATE_O <= !link_enable;
    end
  end

  // summary follows the next-state flags so it tracks status with no lag
  logic [NUM_ALARMS-1:0] next_status;
  assign next_status = (alarm_status_bits & ~clr) | events;
  // a mask written this cycle applies at once, like the status it gates
  logic [NUM_ALARMS-1:0] next_mask;
  assign next_mask = (wr_access && PADDR_I == ADDR_MASK)
    ? PWDATA_I[NUM_ALARMS-1:0] : alarm_mask;
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ALARM_O <= 1'b0;
      CAL_RESULT_PIN_O <= 1'b0;
    end else begin
      ALARM_O <= |(next_status & ~next_mask);
      CAL_RESULT_PIN_O <= ctrl[CTRL_PIN_SEL] && |(next_status & ~next_mask);
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= '0;
      PSLVERR_O <= 1'b0;
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped;
      PRDATA_O <= '0;
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        unique case (PADDR_I)
          ADDR_STATUS: PRDATA_O <= 32'(alarm_status_bits);
          ADDR_MASK: PRDATA_O <= 32'(alarm_mask);
          ADDR_CTRL: PRDATA_O <= 32'(ctrl);
          ADDR_LANES: PRDATA_O <= 32'(per_lane_upset_bits);
          ADDR_SUMMARY: PRDATA_O <= {30'h0, link_state};
          default: PRDATA_O <= '0;
        endcase
      end
    end
  end

  a_status_sticky: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    alarm_status_bits[BIT_OSC] && !clr[BIT_OSC] |=> alarm_status_bits[BIT_OSC])
    else $error("status bit dropped without write-one clear");

  a_osc_mismatch: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    osc_armed && PHASE_ACC_A_I != PHASE_ACC_B_I |=> alarm_status_bits[BIT_OSC])
    else $error("phase mismatch not flagged");

  a_osc_unarmed: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !osc_armed && !alarm_status_bits[BIT_OSC] && !clr[BIT_OSC] |=> !alarm_status_bits[BIT_OSC]
      || $past(osc_armed))
    else $error("oscillator flag set before sync");

  a_clk_mismatch: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    CLOCKS_A_I != CLOCKS_B_I |=> alarm_status_bits[BIT_CLK])
    else $error("clock mismatch not flagged");

  a_pll_unlock: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !PLL_LOCKED_I |=> alarm_status_bits[BIT_PLL])
    else $error("pll unlock not flagged");

  a_lane_bits: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    link_enable && LANE_FIFO_ERR_I[0] |=> per_lane_upset_bits[0]
      && alarm_status_bits[BIT_FIFO])
    else $error("lane upset not recorded");

  a_summary_or: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ##1 ALARM_O == |(alarm_status_bits & ~alarm_mask))
    else $error("summary differs from unmasked status");

  a_pin_alarm: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ##1 CAL_RESULT_PIN_O == (ALARM_O && $past(ctrl[CTRL_PIN_SEL])))
    else $error("pin does not follow alarm");

  sequence s_link_off;
    !link_enable;
  endsequence
  a_link_reset: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_link_off |=> LINK_RESET_O && SER_POWER_DOWN_O && link_state == LS_OFF)
    else $error("link not held off");

  a_sysref_lmfc: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    SYSREF_I |=> lmfc_cnt == 8'h00 && LMFC_EDGE_O)
    else $error("sysref did not reset lmfc");

  a_link_idle: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    link_enable && link_state != LS_DATA |=> alarm_status_bits[BIT_LINK])
    else $error("idle link not flagged");

  a_sysref_realign: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    SYSREF_REALIGN_I |=> alarm_status_bits[BIT_SYSREF])
    else $error("clock realign not flagged");

  a_reinit_link: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    reinit |=> LINK_RESET_O && link_state == LS_OFF)
    else $error("buffer upset did not reinit link");

endmodule

// ### shared/uam_pkg.sv
// Purpose: constants for the upset alarm monitor
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
package uam_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_LANES = 8'h0c;
  localparam logic [7:0] ADDR_SUMMARY = 8'h10;
  // status bit positions
  localparam int BIT_FIFO = 0;
  localparam int BIT_PLL = 1;
  localparam int BIT_LINK = 2;
  localparam int BIT_SYSREF = 3;
  localparam int BIT_OSC = 4;
  localparam int BIT_CLK = 5;
  localparam int NUM_ALARMS = 6;
  // control bit positions
  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_PIN_SEL = 1;
  localparam int CTRL_AUTO_REINIT = 2;
  localparam int CTRL_SYNC_SRC = 3;
  localparam int CTRL_ENC_64B = 4;
  localparam logic [5:0] MASK_RESET = 6'h3f;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int DEFAULT_LANES = 16;
  localparam int DEFAULT_LMFC_LEN = 32;
  typedef enum logic [1:0] {
    LS_OFF = 2'b00,
    LS_SYNC = 2'b01,
    LS_DATA = 2'b11
  } uam_link_e;
endpackage
